// ### core/wcd_regs.svh
`ifndef WCD_REGS_SVH
`define WCD_REGS_SVH

// Register byte offsets on the APB bus.
`define WCD_OFF_CONFIG 12'h000
`define WCD_OFF_CONTROL 12'h004
`define WCD_OFF_WINDOW 12'h008
`define WCD_OFF_STATUS 12'h00c

// Configuration word field positions.
`define WCD_CCS_HI 13
`define WCD_CCS_LO 11
`define WCD_CWS_HI 10
`define WCD_CWS_LO 8
`define WCD_UNIMP_BIT 7
`define WCD_MODE_HI 6
`define WCD_MODE_LO 5
`define WCD_CPS_HI 4
`define WCD_CPS_LO 0

// Control register field positions.
`define WCD_CTL_SWEN 0
`define WCD_CTL_CLK_HI 2
`define WCD_CTL_CLK_LO 1

// Status register field positions.
`define WCD_ST_ACTIVE 0
`define WCD_ST_REF_LO 1
`define WCD_ST_DLY_LO 3
`define WCD_ST_OPEN_LO 7
`define WCD_ST_WINSW 11
`define WCD_ST_KEY 12
`define WCD_ST_LOADED 13

// Reset values and window decode constants.
`define WCD_CFG_RST 14'h0000
`define WCD_CTL_RST 3'h0
`define WCD_WIN_RST 3'h7
`define WCD_EIGHTHS_FULL 4'h8
`define WCD_DLY_BASE 4'h7

`endif

// ### core/wcd_pkg.sv
package wcd_pkg;

	// Configuration load sequence, one-hot.
	typedef enum logic [3:0] {
		WCD_SYNC0 = 4'b0001,
		WCD_SYNC1 = 4'b0010,
		WCD_CAPTURE = 4'b0100,
		WCD_RUN = 4'b1000
	} wcd_state_t;

	// Watchdog reference clock chosen.
	typedef enum logic [1:0] {
		WCD_REF_NONE = 2'h0,
		WCD_REF_LFOSC = 2'h1,
		WCD_REF_MFOSC = 2'h2
	} wcd_ref_t;

	// Whole state of the decoder.
	typedef struct packed {
		wcd_state_t state;
		logic [13:0] sync1;
		logic [13:0] sync2;
		logic [13:0] cfg;
		logic sw_en;
		logic [1:0] sw_clk;
		logic [2:0] win;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic active;
		wcd_ref_t ref_sel;
		logic [3:0] delay;
		logic [3:0] open;
		logic win_sw;
		logic key_req;
	} wcd_state_s_t;

endpackage : wcd_pkg

// ### core/wcd_top.sv
`timescale 1ns/10ps
`include "wcd_regs.svh"

module wcd_top (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Nonvolatile configuration word and core state.
	input wire logic [13:0] nvm_config_word,
	input wire logic sleep_state,
	// Decoded watchdog settings.
	output logic wd_active,
	output wcd_pkg::wcd_ref_t wd_ref_clock_sel,
	output logic [3:0] wd_delay_eighths,
	output logic [3:0] wd_open_eighths,
	output logic [2:0] wd_runtime_window,
	output logic [4:0] wd_prescale_config,
	output logic wd_window_sw_ctrl,
	output logic wd_key_required,
	output logic cfg_loaded
);
	import wcd_pkg::*;

	wcd_state_s_t s;
	wcd_state_s_t next_s;
	logic [1:0] wd_operating_mode;
	logic [2:0] wd_clock_select;
	logic [2:0] wd_window_config;
	logic [13:0] cfg_view;
	logic access_done;
	logic [31:0] read_word;
	logic [31:0] status_word;

	//**************************************************************
	// Field extraction
	//**************************************************************

	// Fields of the captured configuration word.
	assign wd_clock_select = s.cfg[`WCD_CCS_HI:`WCD_CCS_LO];
	assign wd_window_config = s.cfg[`WCD_CWS_HI:`WCD_CWS_LO];
	assign wd_operating_mode = s.cfg[`WCD_MODE_HI:`WCD_MODE_LO];

	// Read view of the word with the unimplemented bit forced high.
	always_comb
	begin
		cfg_view = s.cfg;
		cfg_view[`WCD_UNIMP_BIT] = 1'b1;
	end

	// A transfer completes on the edge that sees pready high.
	assign access_done = psel && penable && s.pready;

	// Status word built from the block's own state.
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[`WCD_ST_ACTIVE] = s.active;
		status_word[`WCD_ST_REF_LO +: 2] = s.ref_sel;
		status_word[`WCD_ST_DLY_LO +: 4] = s.delay;
		status_word[`WCD_ST_OPEN_LO +: 4] = s.open;
		status_word[`WCD_ST_WINSW] = s.win_sw;
		status_word[`WCD_ST_KEY] = s.key_req;
		status_word[`WCD_ST_LOADED] = (s.state == WCD_RUN);
	end

	// Read mux; unmapped addresses read zero.
	always_comb
	begin
		read_word = 32'h00000000;
		if (paddr == `WCD_OFF_CONFIG)
		begin
			read_word[13:0] = cfg_view;
		end
		else if (paddr == `WCD_OFF_CONTROL)
		begin
			read_word[`WCD_CTL_SWEN] = s.sw_en;
			read_word[`WCD_CTL_CLK_HI:`WCD_CTL_CLK_LO] = s.sw_clk;
		end
		else if (paddr == `WCD_OFF_WINDOW)
		begin
			read_word[2:0] = s.win;
		end
		else if (paddr == `WCD_OFF_STATUS)
		begin
			read_word = status_word;
		end
	end

	//**************************************************************
	// Next state
	//**************************************************************

	// Computes the whole next state of the block.
	always_comb
	begin
		next_s = s;
		// Two-stage synchroniser for the nonvolatile word.
		next_s.sync1 = nvm_config_word;
		next_s.sync2 = s.sync1;
		// Load sequence after reset release.
		case (s.state)
			WCD_SYNC0:
			begin
				next_s.state = WCD_SYNC1;
			end
			WCD_SYNC1:
			begin
				next_s.state = WCD_CAPTURE;
			end
			WCD_CAPTURE:
			begin
				next_s.cfg = s.sync2;
				next_s.win = s.sync2[`WCD_CWS_HI:`WCD_CWS_LO];
				if (s.sync2[`WCD_CWS_HI:`WCD_CWS_LO + 1] == 2'b11)
				begin
					next_s.win = 3'h7;
				end
				next_s.state = WCD_RUN;
			end
			WCD_RUN:
			begin
				next_s.state = WCD_RUN;
			end
			default:
			begin
				next_s.state = WCD_SYNC0;
			end
		endcase

		// APB: pready rises in the second access cycle, then falls.
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && penable && !s.pready)
		begin
			next_s.pready = 1'b1;
			next_s.prdata = read_word;
			next_s.pslverr = !(paddr == `WCD_OFF_CONFIG || paddr == `WCD_OFF_CONTROL ||
				paddr == `WCD_OFF_WINDOW || paddr == `WCD_OFF_STATUS);
		end

		// Writes land on the completing edge.
		if (access_done && pwrite)
		begin
			if (paddr == `WCD_OFF_CONTROL)
			begin
				next_s.sw_en = pwdata[`WCD_CTL_SWEN];
				next_s.sw_clk = pwdata[`WCD_CTL_CLK_HI:`WCD_CTL_CLK_LO];
			end
			else if (paddr == `WCD_OFF_WINDOW && s.state == WCD_RUN &&
				wd_window_config[2])
			begin
				next_s.win = pwdata[2:0];
			end
		end

		// Operating mode decode.
		next_s.active = 1'b0;
		if (s.state == WCD_RUN)
		begin
			case (wd_operating_mode)
				2'b11: next_s.active = 1'b1;
				2'b10: next_s.active = !sleep_state;
				2'b01: next_s.active = s.sw_en;
				default: next_s.active = 1'b0;
			endcase
		end

		// Reference clock decode; unlisted codes select nothing.
		case (wd_clock_select)
			3'b000: next_s.ref_sel = WCD_REF_LFOSC;
			3'b001: next_s.ref_sel = WCD_REF_MFOSC;
			3'b111:
			begin
				if (s.sw_clk == 2'b00)
				begin
					next_s.ref_sel = WCD_REF_LFOSC;
				end
				else if (s.sw_clk == 2'b01)
				begin
					next_s.ref_sel = WCD_REF_MFOSC;
				end
				else
				begin
					next_s.ref_sel = WCD_REF_NONE;
				end
			end
			default: next_s.ref_sel = WCD_REF_NONE;
		endcase

		// Window timing in eighths of the period.
		if (s.win[2:1] == 2'b11)
		begin
			next_s.delay = 4'h0;
		end
		else
		begin
			next_s.delay = `WCD_DLY_BASE - {1'b0, s.win};
		end
		next_s.open = `WCD_EIGHTHS_FULL - next_s.delay;
		next_s.win_sw = wd_window_config[2];
		next_s.key_req = !wd_window_config[2];
	end

	//**************************************************************
	// State register
	//**************************************************************

	// Registers the whole state; constants only under reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s.state <= WCD_SYNC0;
			s.sync1 <= `WCD_CFG_RST;
			s.sync2 <= `WCD_CFG_RST;
			s.cfg <= `WCD_CFG_RST;
			s.sw_en <= 1'b0;
			s.sw_clk <= 2'h0;
			s.win <= `WCD_WIN_RST;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
			s.prdata <= 32'h00000000;
			s.active <= 1'b0;
			s.ref_sel <= WCD_REF_NONE;
			s.delay <= 4'h0;
			s.open <= `WCD_EIGHTHS_FULL;
			s.win_sw <= 1'b0;
			s.key_req <= 1'b0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops.
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign wd_active = s.active;
	assign wd_ref_clock_sel = s.ref_sel;
	assign wd_delay_eighths = s.delay;
	assign wd_open_eighths = s.open;
	assign wd_runtime_window = s.win;
	assign wd_prescale_config = s.cfg[`WCD_CPS_HI:`WCD_CPS_LO];
	assign wd_window_sw_ctrl = s.win_sw;
	assign wd_key_required = s.key_req;
	assign cfg_loaded = s.state[3];

	//**************************************************************
	// Assertions
	//**************************************************************

	// Named steps of a bus transfer.
	sequence seq_done_rd(logic [11:0] a);
		psel && penable && s.pready && !pwrite && paddr == a;
	endsequence

	sequence seq_done_wr(logic [11:0] a);
		psel && penable && s.pready && pwrite && paddr == a;
	endsequence

	// Mode checks.
	chk_mode_always_on: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_loaded && wd_operating_mode == 2'b11) |=> wd_active)
		else $error("mode 11 did not keep the watchdog on");
	chk_mode_awake_only: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_loaded && wd_operating_mode == 2'b10) |=> wd_active == !$past(sleep_state))
		else $error("mode 10 did not follow sleep");
	chk_mode_sw_enable: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_loaded && wd_operating_mode == 2'b01) |=> wd_active == $past(s.sw_en))
		else $error("mode 01 did not follow the enable bit");
	chk_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
		(wd_operating_mode == 2'b00) |=> !wd_active)
		else $error("mode 00 let the watchdog run");

	// Clock source checks.
	// The release edge is skipped: the flops still load their reset values on it.
	chk_clk_low_freq: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && wd_clock_select == 3'b000) |=> wd_ref_clock_sel == WCD_REF_LFOSC)
		else $error("select 000 did not pick the low oscillator");
	chk_clk_mid_freq: assert property (@(posedge pclk) disable iff (!presetn)
		(wd_clock_select == 3'b001) |=> wd_ref_clock_sel == WCD_REF_MFOSC)
		else $error("select 001 did not pick the derived oscillator");
	chk_clk_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(wd_clock_select == 3'b010 || wd_clock_select == 3'b110)
		|=> wd_ref_clock_sel == WCD_REF_NONE)
		else $error("a reserved select picked a clock");

	// Window checks.
	chk_window_delay: assert property (@(posedge pclk) disable iff (!presetn)
		(s.win <= 3'h5) |=> (wd_delay_eighths == 4'h7 - {1'b0, $past(s.win)}) &&
		(wd_open_eighths + wd_delay_eighths == 4'h8))
		else $error("window delay does not match the code");
	chk_window_full: assert property (@(posedge pclk) disable iff (!presetn)
		(s.state == WCD_CAPTURE && s.sync2[10:9] == 2'b11)
		|=> wd_runtime_window == 3'h7 ##1 wd_delay_eighths == 4'h0 && wd_open_eighths == 4'h8)
		else $error("codes 11x did not open the window fully");
	chk_window_lock: assert property (@(posedge pclk) disable iff (!presetn)
		(seq_done_wr(`WCD_OFF_WINDOW) ##0 !wd_window_config[2])
		|=> $stable(wd_runtime_window))
		else $error("a locked window was changed by software");

	// Configuration word checks.
	chk_cfg_readback: assert property (@(posedge pclk) disable iff (!presetn)
		seq_done_rd(`WCD_OFF_CONFIG) |-> prdata[13:8] == s.cfg[13:8] &&
		prdata[6:0] == s.cfg[6:0] && prdata[31:14] == 18'h00000)
		else $error("configuration fields read back out of place");
	chk_cfg_bit7_one: assert property (@(posedge pclk) disable iff (!presetn)
		seq_done_rd(`WCD_OFF_CONFIG) |-> prdata[7])
		else $error("bit 7 of the configuration word read as zero");
	chk_cfg_held: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_loaded |=> $stable(s.cfg) && cfg_loaded)
		else $error("configuration word changed while running");

endmodule : wcd_top

// ### core/wcd_top_unused_guard.sv
// All decoder logic lives in wcd_top; this file holds nothing.

// ### sim/watchdog_config_decode_test.sv
`timescale 1ns/10ps
`include "wcd_regs.svh"
module watchdog_config_decode_test;
	import wcd_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, sleep_state, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] nvm_config_word;
	logic wd_active, wd_window_sw_ctrl, wd_key_required, cfg_loaded;
	wcd_ref_t wd_ref_clock_sel;
	logic [3:0] wd_delay_eighths, wd_open_eighths;
	logic [2:0] wd_runtime_window;
	logic [4:0] wd_prescale_config;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	wcd_top wcd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nvm_config_word(nvm_config_word), .sleep_state(sleep_state),
		.wd_active(wd_active), .wd_ref_clock_sel(wd_ref_clock_sel),
		.wd_delay_eighths(wd_delay_eighths), .wd_open_eighths(wd_open_eighths),
		.wd_runtime_window(wd_runtime_window), .wd_prescale_config(wd_prescale_config),
		.wd_window_sw_ctrl(wd_window_sw_ctrl), .wd_key_required(wd_key_required),
		.cfg_loaded(cfg_loaded));
	// *****************************
	// Clock, timeout and reporting.
	// *****************************
	// The clock toggles every half period of 4 ns.
	always #4 pclk = ~pclk;
	// A hung run is cut short and counted as a mismatch.
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// Compares one value and reports any difference.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Resets the block with a new configuration word and waits for the decode.
	task automatic load(input logic [13:0] w);
		@(posedge pclk);
		presetn <= 1'b0;
		nvm_config_word <= w;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : load
	// *****************************
	// Scenarios.
	// *****************************
	// Every mode against every enable and sleep combination.
	task automatic t_modes();
		logic exp;
		for (int m = 0; m < 4; m++)
		begin
			load({3'h0, 3'h7, 1'b0, 2'(m), 5'h00});
			for (int c = 0; c < 4; c++)
			begin
				apb(1'b1, `WCD_OFF_CONTROL, {31'h0, c[0]});
				sleep_state <= c[1];
				repeat (3) @(posedge pclk);
				exp = (m == 3) | ((m == 2) & ~c[1]) | ((m == 1) & c[0]);
				chk("active", exp, wd_active);
			end
		end
		sleep_state <= 1'b0;
	endtask : t_modes
	// Every clock select code, software choice included.
	task automatic t_clocks();
		logic [2:0] codes [8] = '{3'h3, 3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
		wcd_ref_t exp [8] = '{WCD_REF_NONE, WCD_REF_NONE, WCD_REF_NONE, WCD_REF_LFOSC,
			WCD_REF_MFOSC, WCD_REF_NONE, WCD_REF_NONE, WCD_REF_LFOSC};
		for (int i = 0; i < 8; i++)
		begin
			load({codes[i], 3'h7, 1'b0, 2'h3, 5'h00});
			chk("ref", exp[i], wd_ref_clock_sel);
		end
		apb(1'b1, `WCD_OFF_CONTROL, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		chk("ref sw mid", WCD_REF_MFOSC, wd_ref_clock_sel);
		apb(1'b1, `WCD_OFF_CONTROL, 32'h0000_0006);
		repeat (3) @(posedge pclk);
		chk("ref sw none", WCD_REF_NONE, wd_ref_clock_sel);
		apb(1'b0, `WCD_OFF_CONTROL, 32'h0);
		chk("control rd", 32'h0000_0006, rd);
	endtask : t_clocks
	// Every window code, a software write, then a changed stored word.
	task automatic t_windows();
		logic [13:0] w;
		logic [2:0] rw;
		for (int c = 0; c < 8; c++)
		begin
			w = {3'h1, 3'(c), 1'b0, 2'h1, 5'(c * 3 + 1)};
			load(w);
			rw = (c >= 6) ? 3'h7 : 3'(c);
			chk("window", rw, wd_runtime_window);
			chk("delay", (c >= 6) ? 0 : 7 - c, wd_delay_eighths);
			chk("open", (c >= 6) ? 8 : 1 + c, wd_open_eighths);
			chk("sw ctrl", c >= 4, wd_window_sw_ctrl);
			chk("key", c < 4, wd_key_required);
			chk("prescale", w[4:0], wd_prescale_config);
			apb(1'b0, `WCD_OFF_CONFIG, 32'h0);
			chk("config", {18'h0, w | 14'h0080}, rd);
			apb(1'b1, `WCD_OFF_WINDOW, 32'h0000_0002);
			if (c >= 4)
				rw = 3'h2;
			apb(1'b0, `WCD_OFF_WINDOW, 32'h0);
			chk("window rd", rw, rd[2:0]);
			repeat (2) @(posedge pclk);
			chk("delay sw", (rw >= 6) ? 0 : 7 - rw, wd_delay_eighths);
			nvm_config_word <= ~w;
			repeat (4) @(posedge pclk);
			apb(1'b0, `WCD_OFF_CONFIG, 32'h0);
			chk("config held", {18'h0, w | 14'h0080}, rd);
		end
	endtask : t_windows
	// Read-only config write and an unmapped address.
	task automatic t_access();
		load(14'h1a6b);
		apb(1'b1, `WCD_OFF_CONFIG, 32'h0000_0000);
		apb(1'b0, `WCD_OFF_CONFIG, 32'h0);
		chk("config ro", 32'h0000_1aeb, rd);
		chk("config err", 1'b0, err);
		apb(1'b0, `WCD_OFF_STATUS, 32'h0);
		chk("status", 32'h0000_31a9, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", 1'b1, err);
		chk("unmapped data", 32'h0, rd);
	endtask : t_access
	// Reset, reset values, then the scenarios one by one.
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sleep_state = 1'b0;
		nvm_config_word = 14'h0000;
		repeat (8) @(posedge pclk);
		chk("rst window", 3'h7, wd_runtime_window);
		chk("rst loaded", 1'b0, cfg_loaded);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("loaded", 1'b1, cfg_loaded);
		t_modes();
		t_clocks();
		t_windows();
		t_access();
		tally_and_finish();
	end
endmodule : watchdog_config_decode_test
